// ===== core/tpr_defines.vh
// constants for the dual 8-bit timer pair: offsets, fields, resets, timing
`ifndef TPR_DEFINES_VH
`define TPR_DEFINES_VH

// register map (byte offsets on the plain register port)
`define TPR_ADDR_W        4
`define TPR_OFS_RUN       4'h0
`define TPR_OFS_CMP0      4'h2
`define TPR_OFS_CMP1      4'h3
`define TPR_OFS_MODE      4'h4
`define TPR_OFS_FFCR      4'h5
`define TPR_OFS_SYS       4'h6
`define TPR_OFS_STAT      4'h7

// run register fields
`define TPR_RUN_CH0       0
`define TPR_RUN_CH1       1
`define TPR_RUN_PRE       2
`define TPR_RUN_BUFEN     7

// mode register fields
`define TPR_MODE_CK0_LO   0
`define TPR_MODE_CK1_LO   2
`define TPR_MODE_PWM_LO   4
`define TPR_MODE_OP_LO    6

// toggle control register fields
`define TPR_FF_CMD_LO     0
`define TPR_FF_IE         2
`define TPR_FF_SEL        3

// toggle commands
`define TPR_CMD_TOGGLE    2'h0
`define TPR_CMD_CLEAR     2'h1
`define TPR_CMD_SET       2'h2

// operation modes
`define TPR_OP_8BIT       2'h0
`define TPR_OP_16BIT      2'h1
`define TPR_OP_PPG        2'h2
`define TPR_OP_PWM        2'h3

// reset values
`define TPR_RST_RUN       8'h00
`define TPR_RST_MODE      8'h00
`define TPR_RST_FFCR      8'h0c
`define TPR_RST_CMP       8'h00

// prescaler: 9 bits, fed by the selected clock divided by 4
`define TPR_PRE_W         9
`define TPR_IN_DIV        2'h3
`define TPR_OSC_DIV       4'hf

`endif

// ===== core/tpr_channel.v
// one 8-bit up counter with compare value input and comparator
`timescale 1ns/10ps
module tpr_channel
(
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire       run,
  input  wire       tick,
  input  wire       hold_cmp,
  input  wire [7:0] cmp_val,
  output wire       match,
  output wire       ovf,
  output wire [7:0] count
);

  reg  [7:0] cnt_q;
  reg  [7:0] cnt_d;
  wire       hit_eq;

  // ==========================================================
  // comparator
  assign ovf    = tick & (cnt_q == 8'hff);
  // zero compare means "match on overflow"
  assign hit_eq = (cmp_val == 8'h00) ? ovf : (tick & (cnt_q + 8'h01 == cmp_val)); // R9
  // a compare below the count only hits after wraparound, giving a late match
  assign match  = run & ~hold_cmp & hit_eq; // R15
  assign count  = cnt_q;

  // ==========================================================
  // counter next state
  always @*
  begin
    cnt_d = cnt_q;
    if (!run)
      cnt_d = 8'h00; // R8
    else if (match)
      cnt_d = 8'h00; // R10
    else if (tick)
      cnt_d = cnt_q + 8'h01; // R4
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 8'h00; // R8
    else if (clk_en)
      cnt_q <= cnt_d;
  end

endmodule // tpr_channel

// ===== core/tpr_timer_pair.v
// dual 8-bit timer pair with shared prescaler and toggle flip-flop
`timescale 1ns/10ps
`include "tpr_defines.vh"

// Overview of operation
// R1 - a 9-bit prescaler divides its input to make the internal timer clocks
// R2 - prescaler run bit 1 counts; 0 clears prescaler to zero and stops it
// R3 - prescaler input is system clock divided by 4; taps at 1/2,1/8,1/32,1/512
// R4 - each channel has an 8-bit up counter advanced per selected clock pulse
// R5 - channel 0 clock chosen from pin, 1/2, 1/8 or 1/32 taps
// R6 - in 16-bit mode channel 1 counts channel 0 overflows
// R7 - otherwise channel 1 clock is match0, 1/2, 1/32 or 1/512 tap
// R8 - run bit clear holds counter stopped at zero; reset clears and stops both
// R9 - match when counter equals compare; compare zero matches on overflow
// R10 - match clears counter, pulses channel request, toggles flip-flop if enabled
// R11 - channel 0 buffer enable resets to 0 (off); 1 turns it on
// R12 - buffered compare loads on PWM period overflow or PPG cycle start only
// R13 - compare and buffer share an address; buffered writes reach buffer only
// R14 - software writes low then high compare in 16-bit mode; low alone won't compare
// R15 - compare below the count while running matches only after overflow
// R16 - hardware toggles flip-flop only when invert enable is set
// R17 - reset clears the toggle flip-flop to 0
// R18 - command write 01 clears, 10 sets, 00 toggles the flip-flop
// R19 - flip-flop drives the timer output pin when pin selects timer function
// R20 - toggle source depends on mode: 8-bit select, 16-bit, PWM, PPG
// R21 - hardware plus software toggle inverts once; with software set gives 1
// R22 - software stops the timer before changing invert enable
// R23 - mode field: 00 two 8-bit, 01 16-bit, 10 PPG, 11 PWM plus timer
// R24 - hardware toggle with software clear leaves the flip-flop cleared
// R25 - clock select 0 takes gear clock; 1 takes oscillator divided by 16
module tpr_timer_pair
(
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire       gear_tick,
  input  wire       osc_tick,
  input  wire       ext_clock_pin,
  input  wire       pin_timer_func,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output wire       ch0_match_irq,
  output wire       ch1_match_irq,
  output wire       timer_output_pin
);

  // ==========================================================
  // registers
  reg  [7:0] pair_run_control_q;
  reg  [7:0] pair_mode_control_q;
  reg        toggle_invert_enable_q;
  reg        toggle_src_sel_q;
  reg        prescaler_clock_select_q;
  reg  [7:0] cmp0_q;
  reg  [7:0] cmp0_buf_q;
  reg  [7:0] cmp1_q;
  reg        cmp_hi_ok_q;
  reg        timer_toggle_ff_q;
  reg        timer_toggle_ff_d;
  reg  [1:0] in_div_q;
  reg  [3:0] osc_div_q;
  reg  [8:0] presc_q;
  reg  [8:0] presc_d;
  reg        pin_q;
  reg  [7:0] pwm_cnt_q;
  reg  [7:0] rd_d;

  wire       run0  = pair_run_control_q[`TPR_RUN_CH0];
  wire       run1  = pair_run_control_q[`TPR_RUN_CH1];
  wire       prun  = pair_run_control_q[`TPR_RUN_PRE];
  wire       bufen = pair_run_control_q[`TPR_RUN_BUFEN];
  wire [1:0] ck0   = pair_mode_control_q[`TPR_MODE_CK0_LO +: 2];
  wire [1:0] ck1   = pair_mode_control_q[`TPR_MODE_CK1_LO +: 2];
  wire [1:0] pwmc  = pair_mode_control_q[`TPR_MODE_PWM_LO +: 2];
  wire [1:0] opm   = pair_mode_control_q[`TPR_MODE_OP_LO +: 2];
  wire       m16   = (opm == `TPR_OP_16BIT); // R23
  wire       mppg  = (opm == `TPR_OP_PPG);
  wire       mpwm  = (opm == `TPR_OP_PWM);

  wire       wr_run  = reg_wr & (reg_addr == `TPR_OFS_RUN);
  wire       wr_cmp0 = reg_wr & (reg_addr == `TPR_OFS_CMP0);
  wire       wr_cmp1 = reg_wr & (reg_addr == `TPR_OFS_CMP1);
  wire       wr_mode = reg_wr & (reg_addr == `TPR_OFS_MODE);
  wire       wr_ffcr = reg_wr & (reg_addr == `TPR_OFS_FFCR);
  wire       wr_sys  = reg_wr & (reg_addr == `TPR_OFS_SYS);

  // ==========================================================
  // prescaler input: selected source divided by 4
  // oscillator path divides by 16 before the common divide-by-4
  wire sel_tick = prescaler_clock_select_q ? (osc_tick & (osc_div_q == `TPR_OSC_DIV))
                                           : gear_tick; // R25
  wire pre_in   = sel_tick & (in_div_q == `TPR_IN_DIV); // R3

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_div_q  <= 2'h0;
      osc_div_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (!prun)
      begin
        in_div_q  <= 2'h0;
        osc_div_q <= 4'h0;
      end
      else
      begin
        if (osc_tick)
          osc_div_q <= osc_div_q + 4'h1;
        if (sel_tick)
          in_div_q <= in_div_q + 2'h1;
      end
    end
  end

  // 9-bit prescaler; taps fire on the bit's falling transition
  always @*
  begin
    presc_d = presc_q;
    if (!prun)
      presc_d = 9'h000; // R2
    else if (pre_in)
      presc_d = presc_q + 9'h001; // R1
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      presc_q <= 9'h000;
    else if (clk_en)
      presc_q <= presc_d;
  end

  // one-cycle tap pulses at 1/2, 1/8, 1/32 and 1/512 of the input
  wire tap_div2   = pre_in & (presc_q[0]   == 1'b1); // R3
  wire tap_div8   = pre_in & (presc_q[2:0] == 3'h7);
  wire tap_div32  = pre_in & (presc_q[4:0] == 5'h1f);
  wire tap_div512 = pre_in & (presc_q      == 9'h1ff);

  // ==========================================================
  // external clock pin: rising edge counts
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_q <= 1'b0;
    else if (clk_en)
      pin_q <= ext_clock_pin;
  end
  wire pin_rise = ext_clock_pin & ~pin_q;

  // ==========================================================
  // channel clock selection
  wire match0;
  wire match1;
  wire ovf0;
  wire ovf1;
  wire [7:0] count0;
  wire [7:0] count1;
  reg  tick0;
  reg  tick1;

  always @*
  begin
    case (ck0) // R5
      2'h0:    tick0 = pin_rise;
      2'h1:    tick0 = tap_div2;
      2'h2:    tick0 = tap_div8;
      default: tick0 = tap_div32;
    endcase
    if (m16)
      tick1 = ovf0; // R6
    else
      case (ck1) // R7
        2'h0:    tick1 = match0;
        2'h1:    tick1 = tap_div2;
        2'h2:    tick1 = tap_div32;
        default: tick1 = tap_div512;
      endcase
  end

  // in 16-bit mode the low counter runs free and only the pair compares
  wire lo_full = m16 & (count1 == cmp1_q) & cmp_hi_ok_q; // R14
  wire hold0   = m16 & ~lo_full;
  wire hold1   = m16; // R6

  // PPG: channel 0 counter also checks channel 1's compare value
  wire [7:0] cmp1_eff = mppg ? 8'h00 : cmp1_q;

  tpr_channel u_ch0
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .run      (run0),
    .tick     (tick0),
    .hold_cmp (hold0 | mpwm),
    .cmp_val  (cmp0_q),
    .match    (match0),
    .ovf      (ovf0),
    .count    (count0)
  );

  tpr_channel u_ch1
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .run      (run1 & ~(m16 & match0)),
    .tick     (tick1),
    .hold_cmp (hold1 | mppg),
    .cmp_val  (cmp1_eff),
    .match    (match1),
    .ovf      (ovf1),
    .count    (count1)
  );

  // PWM period: 2^6, 2^7 or 2^8 counts of channel 0's clock
  wire [7:0] pwm_top = (pwmc == 2'h1) ? 8'h3f : (pwmc == 2'h2) ? 8'h7f : 8'hff;
  wire pwm_ovf   = mpwm & run0 & tick0 & (pwm_cnt_q == pwm_top);
  wire pwm_duty  = mpwm & run0 & tick0 & (pwm_cnt_q + 8'h01 == cmp0_q);
  // PPG: ch0 counter hits second compare, then restarts at first
  wire ppg_hi    = mppg & run0 & tick0 & (count0 + 8'h01 == cmp1_q);
  wire ppg_start = mppg & match0;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pwm_cnt_q <= 8'h00;
    else if (clk_en)
    begin
      if (!run0 || !mpwm || pwm_ovf)
        pwm_cnt_q <= 8'h00;
      else if (tick0)
        pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end
  end

  // channel requests are one-cycle pulses: ch0 on its match (PWM: period overflow, 16-bit: none), ch1 on its match (16-bit: pair match)
  assign ch0_match_irq = clk_en & (mpwm ? pwm_ovf : match0 & ~m16); // R10
  assign ch1_match_irq = clk_en & (m16 ? match0 : match1); // R10

  // ==========================================================
  // control registers
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pair_run_control_q       <= `TPR_RST_RUN; // R11
      pair_mode_control_q      <= `TPR_RST_MODE;
      toggle_invert_enable_q   <= 1'b1;
      toggle_src_sel_q         <= 1'b1;
      prescaler_clock_select_q <= 1'b0;
      cmp1_q                   <= `TPR_RST_CMP;
      cmp_hi_ok_q              <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_run)
        pair_run_control_q <= reg_wdata & 8'h87;
      if (wr_mode)
        pair_mode_control_q <= reg_wdata;
      // invert enable must only change while stopped; not guarded here
      if (wr_ffcr)
      begin
        toggle_invert_enable_q <= reg_wdata[`TPR_FF_IE]; // R22
        toggle_src_sel_q       <= reg_wdata[`TPR_FF_SEL];
      end
      if (wr_sys)
        prescaler_clock_select_q <= reg_wdata[0];
      if (wr_cmp1)
        cmp1_q <= reg_wdata;
      // low byte write disarms the pair until the high byte follows
      if (wr_cmp1)
        cmp_hi_ok_q <= 1'b1; // R14
      else if (wr_cmp0)
        cmp_hi_ok_q <= 1'b0;
    end
  end

  // ==========================================================
  // channel 0 compare and its buffer
  wire buf_load = bufen & ((mpwm & pwm_ovf) | ppg_start); // R12

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp0_q     <= `TPR_RST_CMP;
      cmp0_buf_q <= `TPR_RST_CMP;
    end
    else if (clk_en)
    begin
      if (wr_cmp0)
        cmp0_buf_q <= reg_wdata; // R13
      if (wr_cmp0 && !bufen)
        cmp0_q <= reg_wdata; // R13
      else if (buf_load)
        cmp0_q <= cmp0_buf_q; // R12
    end
  end

  // ==========================================================
  // toggle flip-flop
  reg hw_tgl;
  always @*
  begin
    case (opm) // R20
      `TPR_OP_8BIT:  hw_tgl = toggle_src_sel_q ? match1 : match0;
      `TPR_OP_16BIT: hw_tgl = match0;
      `TPR_OP_PPG:   hw_tgl = ppg_start | ppg_hi;
      default:       hw_tgl = pwm_duty | pwm_ovf;
    endcase
  end
  wire hw_inv = hw_tgl & toggle_invert_enable_q; // R16

  always @*
  begin
    timer_toggle_ff_d = timer_toggle_ff_q;
    if (wr_ffcr)
      case (reg_wdata[`TPR_FF_CMD_LO +: 2]) // R18
        `TPR_CMD_TOGGLE: timer_toggle_ff_d = ~timer_toggle_ff_q; // R21
        `TPR_CMD_CLEAR:  timer_toggle_ff_d = 1'b0; // R24
        `TPR_CMD_SET:    timer_toggle_ff_d = 1'b1; // R21
        default:         timer_toggle_ff_d = hw_inv ? ~timer_toggle_ff_q : timer_toggle_ff_q;
      endcase
    else if (hw_inv)
      timer_toggle_ff_d = ~timer_toggle_ff_q; // R10
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_toggle_ff_q <= 1'b0; // R17
    else if (clk_en)
      timer_toggle_ff_q <= timer_toggle_ff_d;
  end

  assign timer_output_pin = pin_timer_func & timer_toggle_ff_q; // R19

  // ==========================================================
  // read port: data one cycle after the strobe, zero otherwise
  always @*
  begin
    case (reg_addr)
      `TPR_OFS_RUN:  rd_d = pair_run_control_q | 8'h70;
      `TPR_OFS_CMP0: rd_d = cmp0_q;
      `TPR_OFS_CMP1: rd_d = cmp1_q;
      `TPR_OFS_MODE: rd_d = pair_mode_control_q;
      `TPR_OFS_FFCR: rd_d = {4'h0, toggle_src_sel_q, toggle_invert_enable_q, 2'h3};
      `TPR_OFS_SYS:  rd_d = {7'h00, prescaler_clock_select_q};
      `TPR_OFS_STAT: rd_d = count0;
      default:       rd_d = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_d : 8'h00;
  end

endmodule // tpr_timer_pair

// ===== tb/tpr_timer_pair_sva.sv
// port-level checker for the timer pair
`timescale 1ns/10ps
`include "tpr_defines.vh"
module tpr_timer_pair_sva
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       pin_timer_func,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       ch0_match_irq,
  input wire logic       ch1_match_irq,
  input wire logic       timer_output_pin
);
  // ============================================================
  // helpers
  default clocking cb @(posedge ref_clk); endclocking
  wire logic ffw = reg_wr && clk_en && (reg_addr == `TPR_OFS_FFCR);
  wire logic stop0 = reg_wr && clk_en && (reg_addr == `TPR_OFS_RUN) && !reg_wdata[`TPR_RUN_CH0];

  // ============================================================
  // properties
  // no disable here: reset itself is the cause being checked
  property p_reset_quiet;
    !rst_n |-> !timer_output_pin && !ch0_match_irq && !ch1_match_irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
  property p_ff_set;
    disable iff (!rst_n) ffw && reg_wdata[1:0] == `TPR_CMD_SET |=> timer_output_pin == pin_timer_func;
  endproperty
  a_ff_set: assert property (p_ff_set) else $error("set command not seen on pin");
  // a coinciding hardware toggle must not undo a clear
  property p_ff_clear;
    disable iff (!rst_n) ffw && reg_wdata[1:0] == `TPR_CMD_CLEAR |=> !timer_output_pin;
  endproperty
  a_ff_clear: assert property (p_ff_clear) else $error("clear command not seen on pin");
  property p_ff_toggle;
    disable iff (!rst_n)
      ffw && reg_wdata[1:0] == `TPR_CMD_TOGGLE && pin_timer_func ##1 pin_timer_func
      |-> timer_output_pin != $past(timer_output_pin);
  endproperty
  a_ff_toggle: assert property (p_ff_toggle) else $error("toggle command did not invert once");
  property p_pin_gate;
    disable iff (!rst_n) !pin_timer_func |-> !timer_output_pin;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin driven while not timer function");
  property p_irq0_pulse;
    disable iff (!rst_n) ch0_match_irq |=> !ch0_match_irq;
  endproperty
  a_irq0_pulse: assert property (p_irq0_pulse) else $error("ch0 request wider than one cycle");
  property p_irq1_pulse;
    disable iff (!rst_n) $rose(ch1_match_irq) |=> $fell(ch1_match_irq);
  endproperty
  a_irq1_pulse: assert property (p_irq1_pulse) else $error("ch1 request wider than one cycle");
  property p_stop_quiet;
    disable iff (!rst_n) stop0 |=> !ch0_match_irq [*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("ch0 request while stopped");

  // ============================================================
  // coverage of the main scenarios
  c_irq0: cover property (disable iff (!rst_n) ch0_match_irq);
  c_irq1: cover property (disable iff (!rst_n) ch1_match_irq);
  c_ff_set: cover property (disable iff (!rst_n) ffw ##1 timer_output_pin);
endmodule // tpr_timer_pair_sva

bind tpr_timer_pair tpr_timer_pair_sva tpr_timer_pair_sva_inst
(
  .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .pin_timer_func(pin_timer_func),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .ch0_match_irq(ch0_match_irq), .ch1_match_irq(ch1_match_irq),
  .timer_output_pin(timer_output_pin)
);

// ===== tb/tpr_ext_model.sv
// far-side model: external count clock source and output pin watcher
`timescale 1ns/10ps
module tpr_ext_model
(
  input  wire logic ref_clk,
  input  wire logic timer_output_pin,
  output logic      ext_clock_pin
);
  int   toggles;
  logic last_q;

  // ============================================================
  // idle low between bursts so no stray edge is counted
  initial
  begin
    ext_clock_pin = 1'b0;
    toggles = 0;
    last_q = 1'b0;
  end

  // count pin flips mid-cycle, clear of the launching edge
  always @(negedge ref_clk)
  begin
    if (timer_output_pin !== last_q)
      toggles++;
    last_q = timer_output_pin;
  end

  // n rising edges, w cycles high and w+1 low between them; small w is the fast case
  task pulse(input int n, input int w);
    repeat (n)
    begin
      @(posedge ref_clk);
      ext_clock_pin <= 1'b1;
      repeat (w) @(posedge ref_clk);
      ext_clock_pin <= 1'b0;
      repeat (w) @(posedge ref_clk);
    end
  endtask
endmodule // tpr_ext_model

// ===== tb/tpr_timer_pair_bench.sv
// self-checking bench for the timer pair
`timescale 1ns/10ps
`include "tpr_defines.vh"
module tpr_timer_pair_bench;
  localparam int PIN = 4;  // cycles per prescaler input pulse, ticks held high
  logic       ref_clk, rst_n, clk_en, gear_tick, osc_tick, pin_timer_func;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic       reg_wr, reg_rd, ext_clock_pin, ch0_match_irq, ch1_match_irq, timer_output_pin;
  int         bad_count, num_checks, irq0_cnt, t0;
  logic [3:0] ra [6] = '{`TPR_OFS_RUN, `TPR_OFS_MODE, `TPR_OFS_FFCR, `TPR_OFS_CMP1,
                         `TPR_OFS_STAT, 4'h1};
  logic [7:0] re [6] = '{`TPR_RST_RUN | 8'h70, `TPR_RST_MODE, `TPR_RST_FFCR | 8'h03,
                         `TPR_RST_CMP, 8'h00, 8'h00};
  logic [1:0] fc [5] = '{`TPR_CMD_SET, `TPR_CMD_CLEAR, `TPR_CMD_TOGGLE, `TPR_CMD_TOGGLE, 2'h3};
  logic       fe [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  tpr_timer_pair tpr_timer_pair_inst
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .gear_tick(gear_tick),
    .osc_tick(osc_tick), .ext_clock_pin(ext_clock_pin), .pin_timer_func(pin_timer_func),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ch0_match_irq(ch0_match_irq), .ch1_match_irq(ch1_match_irq),
    .timer_output_pin(timer_output_pin)
  );
  tpr_ext_model ext_model
  (
    .ref_clk(ref_clk), .timer_output_pin(timer_output_pin), .ext_clock_pin(ext_clock_pin)
  );

  // ============================================================
  // clock, request counter, watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk)
    if (ch0_match_irq === 1'b1)
      irq0_cnt++;
  // longest expected run is about 20k cycles
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    finish_test;
  end

  // ============================================================
  // register port and comparison tasks
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // skip the first request after setup, then time one full period
  task meas(input logic sel, input int exp);
    int n;
    n = 0;
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(negedge ref_clk);
        n++;
      end
      while ((sel ? ch1_match_irq : ch0_match_irq) !== 1'b1 && n < 5000);
    end
    chk(n[15:0], exp[15:0]);
  endtask
  // stop everything before reconfiguring, low compare byte first
  task cfg(input logic [7:0] sys, mode, c0, c1, input logic sel, input int exp);
    wr(`TPR_OFS_RUN, 8'h00);
    wr(`TPR_OFS_SYS, sys);
    wr(`TPR_OFS_MODE, mode);
    wr(`TPR_OFS_CMP0, c0);
    wr(`TPR_OFS_CMP1, c1);
    wr(`TPR_OFS_RUN, 8'h07);
    meas(sel, exp);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ============================================================
  // test sequence
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    gear_tick = 1'b1;
    osc_tick = 1'b1;
    pin_timer_func = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bad_count = 0;
    num_checks = 0;
    irq0_cnt = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, unmapped place reads zero
    foreach (ra[i])
    begin
      rd(ra[i], rv);
      chk({8'h00, rv}, {8'h00, re[i]});
    end
    chk({15'h0000, timer_output_pin}, 16'h0000);
    // software commands, invert enabled, ch0 as source
    foreach (fc[i])
    begin
      wr(`TPR_OFS_FFCR, {6'h01, fc[i]});
      @(negedge ref_clk);
      chk({15'h0000, timer_output_pin}, {15'h0000, fe[i]});
    end
    wr(`TPR_OFS_FFCR, {6'h01, `TPR_CMD_SET});
    pin_timer_func <= 1'b0;
    @(negedge ref_clk);
    chk({15'h0000, timer_output_pin}, 16'h0000);
    @(posedge ref_clk);
    pin_timer_func <= 1'b1;
    wr(`TPR_OFS_FFCR, {6'h01, `TPR_CMD_CLEAR});
    // external pin clock, fast then slow edges; flip count starts after the clear settles
    wr(`TPR_OFS_MODE, 8'h00);
    t0 = ext_model.toggles;
    wr(`TPR_OFS_CMP0, 8'h03);
    wr(`TPR_OFS_RUN, 8'h01);
    ext_model.pulse(3, 1);
    repeat (6) @(negedge ref_clk);
    chk(irq0_cnt[15:0], 16'h0001);
    chk({15'h0000, timer_output_pin}, 16'h0001);
    ext_model.pulse(4, 5);
    repeat (6) @(negedge ref_clk);
    chk(irq0_cnt[15:0], 16'h0002);
    rd(`TPR_OFS_STAT, rv);
    chk({8'h00, rv}, 16'h0001);
    wr(`TPR_OFS_RUN, 8'h00);
    rd(`TPR_OFS_STAT, rv);
    chk({8'h00, rv}, 16'h0000);
    wr(`TPR_OFS_FFCR, 8'h03);
    wr(`TPR_OFS_RUN, 8'h01);
    ext_model.pulse(3, 2);
    repeat (6) @(negedge ref_clk);
    chk(irq0_cnt[15:0], 16'h0003);
    chk({15'h0000, timer_output_pin}, 16'h0000);
    chk(16'(ext_model.toggles - t0), 16'h0002);
    // prescaler held stopped: taps never fire
    wr(`TPR_OFS_RUN, 8'h00);
    wr(`TPR_OFS_MODE, 8'h01);
    wr(`TPR_OFS_CMP0, 8'h05);
    wr(`TPR_OFS_RUN, 8'h03);
    repeat (300) @(posedge ref_clk);
    chk(irq0_cnt[15:0], 16'h0003);
    // clock choices, compare zero, chaining; tap n fires every PIN*n cycles
    cfg(8'h00, 8'h01, 8'h05, 8'h00, 1'b0, 5 * PIN * 2);
    cfg(8'h00, 8'h02, 8'h05, 8'h00, 1'b0, 5 * PIN * 8);
    cfg(8'h00, 8'h03, 8'h05, 8'h00, 1'b0, 5 * PIN * 32);
    cfg(8'h00, 8'h01, 8'h00, 8'h00, 1'b0, 256 * PIN * 2);
    cfg(8'h01, 8'h01, 8'h05, 8'h00, 1'b0, 5 * 16 * PIN * 2);
    cfg(8'h00, 8'h01, 8'h02, 8'h03, 1'b1, 6 * PIN * 2);
    cfg(8'h00, 8'h05, 8'h00, 8'h05, 1'b1, 5 * PIN * 2);
    cfg(8'h00, 8'h0c, 8'h00, 8'h01, 1'b1, PIN * 512);
    cfg(8'h00, 8'h41, 8'h10, 8'h01, 1'b1, 272 * PIN * 2);
    // double buffer: in timer mode buffered writes never reach the compare
    cfg(8'h00, 8'h01, 8'h05, 8'h00, 1'b0, 5 * PIN * 2);
    wr(`TPR_OFS_RUN, 8'h87);
    rd(`TPR_OFS_RUN, rv);
    chk({8'h00, rv}, 16'h00f7);
    wr(`TPR_OFS_CMP0, 8'h09);
    meas(1'b0, 5 * PIN * 2);
    wr(`TPR_OFS_RUN, 8'h07);
    wr(`TPR_OFS_CMP0, 8'h09);
    meas(1'b0, 9 * PIN * 2);
    // PWM: request on each 2^6 period; buffered compare moves in only at period end
    cfg(8'h00, 8'hd1, 8'h05, 8'h00, 1'b0, 64 * PIN * 2);
    wr(`TPR_OFS_RUN, 8'h87);
    wr(`TPR_OFS_CMP0, 8'h20);
    rd(`TPR_OFS_CMP0, rv);
    chk({8'h00, rv}, 16'h0005);
    meas(1'b0, 64 * PIN * 2);
    rd(`TPR_OFS_CMP0, rv);
    chk({8'h00, rv}, 16'h0020);
    finish_test;
  end
endmodule // tpr_timer_pair_bench
